// >>> verilog/tmsa_consts.svh
`ifndef TMSA_CONSTS_SVH
`define TMSA_CONSTS_SVH
// Overview of operation
// RULE1: serial port works only while the test pin is above the test-entry level
// RULE2: serial data input is sampled on every rising serial clock edge
// RULE3: serial data output changes only on falling serial clock edges; the code also clears it at once when the port turns off
// RULE4: link uses clock idle low and first-edge sampling, mode zero
// RULE5: test operation entered only by a key sequence written after reset
// RULE6: converter test needs 0xAA, 0x55, 0x1D in order at address 0x30
// RULE7: converter test disables filter pin buffers and feeds converter from that pin
// RULE8: converter test ends on power loss or test pin falling below entry level
// RULE9: a fuse programming run started over the port ends within 2 ms
// RULE10: 16-bit frame, MSB first: address 15..10, direction bit 9, data 7..0
// RULE11: addressed register content drives data output on falling edges 8 to 15
// RULE12: write frames capture data bits at rising edges 9 to 16
// RULE13: an out-of-order key write restarts matching; normal mode until full sequence

// frame layout
`define TMSA_ADDR_MSB 15
`define TMSA_ADDR_LSB 10
`define TMSA_RW_BIT 9
`define TMSA_DATA_MSB 7
`define TMSA_LAST_RISE 5'h0F
`define TMSA_RD_LOAD_CNT 5'h08
`define TMSA_RD_END_CNT 5'h0F

// register offsets and values
`define TMSA_KEY_ADDR 6'h30
`define TMSA_KEY_FIRST 8'hAA
`define TMSA_KEY_SECOND 8'h55
`define TMSA_KEY_ADC_TEST 8'h1D
`define TMSA_FUSE_CTRL_ADDR 6'h20
`define TMSA_FUSE_START 8'h05
`define TMSA_STATUS_ADDR 6'h31
`define TMSA_STATUS_RESET 8'h00

// fuse programming time
`define TMSA_FUSE_PROGRAM_TIME_MS 2
`define TMSA_CORE_CLK_KHZ 50000
`define TMSA_FUSE_PROGRAM_CYCLES (`TMSA_FUSE_PROGRAM_TIME_MS * `TMSA_CORE_CLK_KHZ)
`define TMSA_FUSE_CNT_W 17
`endif

// >>> verilog/tmsa_pkg.sv
package tmsa_pkg;

  typedef struct packed {
    logic [5:0] addr;
    logic rw;
    logic spare;
    logic [7:0] data;
  } tmsa_frame_t;

  typedef enum logic [3:0] {
    KEY_IDLE = 4'h1,
    KEY_GOT_FIRST = 4'h2,
    KEY_GOT_SECOND = 4'h4,
    KEY_ADC_TEST = 4'h8
  } tmsa_key_state_t;

  typedef enum logic [2:0] {
    FUSE_IDLE = 3'h1,
    FUSE_BUSY = 3'h2,
    FUSE_DONE = 3'h4
  } tmsa_fuse_state_t;

  typedef struct packed {
    logic buffers_off;
    logic input_from_filter_capacitor_pin;
  } tmsa_adc_ctrl_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic fuse_done;
    logic fuse_busy;
    logic rsv_mid;
    logic key_second;
    logic key_first;
    logic adc_test;
  } tmsa_status_t;

  typedef struct packed {
    logic [4:0] bit_cnt;
    logic [14:0] shift;
    tmsa_frame_t word;
    logic toggle;
  } tmsa_rise_state_t;

  typedef struct packed {
    logic [7:0] dout_sh;
    logic dout;
  } tmsa_fall_state_t;

  typedef struct packed {
    logic tog_d;
    logic port_off;
    logic port_on;
    tmsa_key_state_t key;
    tmsa_adc_ctrl_t adc;
    tmsa_status_t status;
    logic fuse_start;
  } tmsa_core_state_t;

  typedef struct packed {
    tmsa_fuse_state_t st;
    logic [16:0] cnt;
  } tmsa_fuse_reg_t;

endpackage : tmsa_pkg

// >>> verilog/tmsa_sync.sv
`timescale 1ns/10ps
module tmsa_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : tmsa_sync

// >>> verilog/tmsa_fuse_timer.sv
`timescale 1ns/10ps
`include "tmsa_consts.svh"
module tmsa_fuse_timer import tmsa_pkg::*; #(
  parameter int CYCLES = `TMSA_FUSE_PROGRAM_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic abort,
  // state
  output logic busy,
  output logic done
);

  localparam logic [16:0] LAST = 17'(CYCLES - 1);

  tmsa_fuse_reg_t r;
  tmsa_fuse_reg_t n;

  always_comb begin
    n = r;
    unique case (r.st)
      FUSE_IDLE, FUSE_DONE: begin
        if (start) begin
          n.st = FUSE_BUSY;
          n.cnt = '0;
        end
      end
      FUSE_BUSY: begin
        // RULE9: bounded programming run
        if (r.cnt == LAST) begin
          n.st = FUSE_DONE;
        end else begin
          n.cnt = r.cnt + 17'h00001;
        end
      end
      default: begin
        n.st = FUSE_IDLE;
      end
    endcase
    if (abort) begin
      n.st = FUSE_IDLE;
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r.st <= FUSE_IDLE;
      r.cnt <= '0;
    end else begin
      r <= n;
    end
  end

  assign busy = r.st[1];
  assign done = r.st[2];

endmodule : tmsa_fuse_timer

// >>> verilog/tmsa_top.sv
`timescale 1ns/10ps
`include "tmsa_consts.svh"
module tmsa_top import tmsa_pkg::*; #(
  parameter int FUSE_PROG_CYCLES = `TMSA_FUSE_PROGRAM_CYCLES
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // test pin comparator
  input wire logic test_entry_voltage_above,
  // serial link
  input wire logic spi_clk,
  input wire logic spi_din,
  output logic spi_dout,
  // converter test configuration
  output tmsa_adc_ctrl_t adc_ctrl,
  // fuse programming and port state
  output logic fuse_prog_active,
  output logic port_enabled
);

  // ------------------------------------------------------------
  // core domain state
  // ------------------------------------------------------------
  tmsa_core_state_t core_r;
  tmsa_core_state_t core_nxt;

  logic [1:0] core_sync_in;
  logic [1:0] core_sync_q;
  logic tog_s;
  logic test_s;
  logic frame_evt;
  logic fuse_busy;
  logic fuse_done;
  tmsa_frame_t rx;

  // ------------------------------------------------------------
  // link domain state
  // ------------------------------------------------------------
  tmsa_rise_state_t rise_r;
  tmsa_rise_state_t rise_nxt;
  tmsa_fall_state_t fall_r;
  tmsa_fall_state_t fall_nxt;

  logic link_rst;
  logic [7:0] status_link;
  logic [5:0] rd_addr;
  logic [7:0] rd_byte;

  // ------------------------------------------------------------
  // crossings into the core domain
  // ------------------------------------------------------------
  assign core_sync_in = {rise_r.toggle, test_entry_voltage_above};

  tmsa_sync #(
    .WIDTH(2)
  ) u_core_sync (
    .clk(core_clk),
    .rst(reset),
    .d(core_sync_in),
    .q(core_sync_q)
  );

  assign tog_s = core_sync_q[1];
  assign test_s = core_sync_q[0];

  // word is stable for a whole frame after its toggle flips
  assign frame_evt = tog_s ^ core_r.tog_d;
  assign rx = rise_r.word;

  // ------------------------------------------------------------
  // fuse programming timer
  // ------------------------------------------------------------
  tmsa_fuse_timer #(
    .CYCLES(FUSE_PROG_CYCLES)
  ) u_fuse (
    .clk(core_clk),
    .rst(reset),
    .start(core_r.fuse_start),
    .abort(core_r.port_off),
    .busy(fuse_busy),
    .done(fuse_done)
  );

  // ------------------------------------------------------------
  // core next state
  // ------------------------------------------------------------
  always_comb begin
    core_nxt = core_r;
    core_nxt.tog_d = tog_s;
    core_nxt.fuse_start = 1'b0;
    // RULE1: port only alive above entry level
    core_nxt.port_off = ~test_s;
    // separate flop so the port state output needs no gate after it
    core_nxt.port_on = test_s;

    // RULE8: drop out of test when pin falls
    if (core_r.port_off) begin
      core_nxt.key = KEY_IDLE;
    end else if (frame_evt && rx.rw && (rx.addr == `TMSA_KEY_ADDR)) begin
      // RULE5: key sequence gates test entry
      unique case (core_r.key)
        KEY_IDLE: begin
          if (rx.data == `TMSA_KEY_FIRST) begin
            core_nxt.key = KEY_GOT_FIRST;
          end
        end
        KEY_GOT_FIRST: begin
          // RULE6: second key value
          if (rx.data == `TMSA_KEY_SECOND) begin
            core_nxt.key = KEY_GOT_SECOND;
          // RULE13: restart on broken order
          end else if (rx.data == `TMSA_KEY_FIRST) begin
            core_nxt.key = KEY_GOT_FIRST;
          end else begin
            core_nxt.key = KEY_IDLE;
          end
        end
        KEY_GOT_SECOND: begin
          // RULE6: final key selects converter test
          if (rx.data == `TMSA_KEY_ADC_TEST) begin
            core_nxt.key = KEY_ADC_TEST;
          // RULE13: restart on broken order
          end else if (rx.data == `TMSA_KEY_FIRST) begin
            core_nxt.key = KEY_GOT_FIRST;
          end else begin
            core_nxt.key = KEY_IDLE;
          end
        end
        KEY_ADC_TEST: begin
          // only reset or the test pin leaves this mode
          core_nxt.key = KEY_ADC_TEST;
        end
        default: begin
          core_nxt.key = KEY_IDLE;
        end
      endcase
    end

    // RULE9: start of a fuse programming run
    if (!core_r.port_off && frame_evt && rx.rw &&
        (rx.addr == `TMSA_FUSE_CTRL_ADDR) &&
        (rx.data == `TMSA_FUSE_START) && !fuse_busy) begin
      core_nxt.fuse_start = 1'b1;
    end

    // RULE7: reroute converter input in test mode
    core_nxt.adc.buffers_off = (core_nxt.key == KEY_ADC_TEST);
    core_nxt.adc.input_from_filter_capacitor_pin = (core_nxt.key == KEY_ADC_TEST);

    core_nxt.status = `TMSA_STATUS_RESET;
    core_nxt.status.adc_test = (core_r.key == KEY_ADC_TEST);
    core_nxt.status.key_first = (core_r.key == KEY_GOT_FIRST);
    core_nxt.status.key_second = (core_r.key == KEY_GOT_SECOND);
    core_nxt.status.fuse_busy = fuse_busy;
    core_nxt.status.fuse_done = fuse_done;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      core_r.tog_d <= 1'b0;
      core_r.port_off <= 1'b1;
      core_r.port_on <= 1'b0;
      core_r.key <= KEY_IDLE;
      core_r.adc <= '0;
      core_r.status <= `TMSA_STATUS_RESET;
      core_r.fuse_start <= 1'b0;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign adc_ctrl = core_r.adc;
  assign port_enabled = core_r.port_on;
  assign fuse_prog_active = core_r.status.fuse_busy;

  // ------------------------------------------------------------
  // link domain
  // ------------------------------------------------------------
  // RULE1: link held cleared while the port is off
  assign link_rst = core_r.port_off;

  // status changes rarely and is only read mid-frame, so a
  // per-bit level sync is enough; a torn byte is possible
  // only if status moves in the very frame that reads it
  tmsa_sync #(
    .WIDTH(8)
  ) u_link_sync (
    .clk(spi_clk),
    .rst(link_rst),
    .d(core_r.status),
    .q(status_link)
  );

  // RULE10: address sits in the first six bits shifted in
  assign rd_addr = rise_r.shift[7:2];

  // key register is write-only and reads as zero
  always_comb begin
    rd_byte = 8'h00;
    if (rd_addr == `TMSA_STATUS_ADDR) begin
      rd_byte = status_link;
    end
  end

  always_comb begin
    rise_nxt = rise_r;
    // RULE2: shift input on each rising edge
    rise_nxt.shift = {rise_r.shift[13:0], spi_din};
    // RULE12: sixteenth rising edge closes the word
    if (rise_r.bit_cnt == `TMSA_LAST_RISE) begin
      // RULE10: MSB first word assembly
      rise_nxt.word = {rise_r.shift, spi_din};
      rise_nxt.toggle = ~rise_r.toggle;
      rise_nxt.bit_cnt = 5'h00;
    end else begin
      rise_nxt.bit_cnt = rise_r.bit_cnt + 5'h01;
    end
  end

  // RULE4: idle-low clock, first edge samples
  always_ff @(posedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      rise_r <= '0;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  always_comb begin
    fall_nxt = fall_r;
    // RULE11: load addressed byte on falling edge 8
    if (rise_r.bit_cnt == `TMSA_RD_LOAD_CNT) begin
      fall_nxt.dout = rd_byte[`TMSA_DATA_MSB];
      fall_nxt.dout_sh = {rd_byte[6:0], 1'b0};
    end else if ((rise_r.bit_cnt > `TMSA_RD_LOAD_CNT) &&
                 (rise_r.bit_cnt <= `TMSA_RD_END_CNT)) begin
      // RULE11: remaining bits through edge 15
      fall_nxt.dout = fall_r.dout_sh[7];
      fall_nxt.dout_sh = {fall_r.dout_sh[6:0], 1'b0};
    end else begin
      fall_nxt.dout = 1'b0;
      fall_nxt.dout_sh = 8'h00;
    end
  end

  // RULE3: output moves on falling edges, and clears at once when the port turns off
  always_ff @(negedge spi_clk or posedge link_rst) begin
    if (link_rst) begin
      fall_r <= '0;
    end else begin
      fall_r <= fall_nxt;
    end
  end

  assign spi_dout = fall_r.dout;

endmodule : tmsa_top

// >>> testbench/tmsa_host.sv
`timescale 1ns/10ps
module tmsa_host (
  // link
  output logic spi_clk,
  output logic spi_din,
  input wire logic spi_dout
);
  int gap = 13;
  initial begin
    spi_clk = 1'b0;
    spi_din = 1'b0;
  end
  // gap alternates so frames come both promptly and slowly
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    #(gap);
    gap = (gap == 13) ? 1300 : 13;
    for (int i = 15; i >= 0; i--) begin
      spi_din = w[i];
      #80 spi_clk = 1'b1;
      if (i < 8) rd[i] = spi_dout;
      #80 spi_clk = 1'b0;
    end
    // released line shows the inverse, never a held value
    spi_din = ~spi_din;
  endtask : xfer
endmodule : tmsa_host

// >>> testbench/tmsa_top_chk.sv
`timescale 1ns/10ps
module tmsa_top_chk import tmsa_pkg::*; #(
  parameter int FUSE_PROG_CYCLES = 20
) (
  // core
  input wire logic core_clk,
  input wire logic reset,
  input wire logic test_entry_voltage_above,
  // link
  input wire logic spi_clk,
  input wire logic spi_din,
  input wire logic spi_dout,
  // outputs
  input wire tmsa_adc_ctrl_t adc_ctrl,
  input wire logic fuse_prog_active,
  input wire logic port_enabled
);
  logic [16:0] fcnt_r;
  logic [3:0] rcnt_r;
  always_ff @(posedge core_clk) fcnt_r <= (reset || !fuse_prog_active) ? 17'h0 : fcnt_r + 17'h1;
  always_ff @(posedge spi_clk or negedge port_enabled) rcnt_r <= !port_enabled ? 4'h0 : rcnt_r + 4'h1;
  property p_port_off;
    @(posedge core_clk) disable iff (reset) !test_entry_voltage_above [*3] |-> ##1 !port_enabled;
  endproperty
  property p_port_on;
    @(posedge core_clk) disable iff (reset) test_entry_voltage_above [*4] |-> port_enabled;
  endproperty
  property p_adc_clear;
    @(posedge core_clk) disable iff (reset) !port_enabled |=> adc_ctrl == 2'h0;
  endproperty
  property p_adc_pair;
    @(posedge core_clk) disable iff (reset) adc_ctrl.buffers_off == adc_ctrl.input_from_filter_capacitor_pin;
  endproperty
  property p_adc_rise;
    @(posedge core_clk) disable iff (reset) $rose(adc_ctrl.buffers_off) |-> $past(port_enabled, 4);
  endproperty
  property p_fuse_len;
    @(posedge core_clk) disable iff (reset) $fell(fuse_prog_active) && port_enabled |-> fcnt_r == FUSE_PROG_CYCLES;
  endproperty
  property p_fuse_abort;
    @(posedge core_clk) disable iff (reset) !port_enabled |-> ##2 !fuse_prog_active;
  endproperty
  property p_fuse_bound;
    @(posedge core_clk) disable iff (reset) fcnt_r <= FUSE_PROG_CYCLES;
  endproperty
  property p_dout_idle;
    @(posedge spi_clk) disable iff (reset || !port_enabled) rcnt_r < 4'h8 |-> !spi_dout;
  endproperty
  property p_dout_fall;
    @(posedge core_clk) disable iff (reset) $changed(spi_dout) |-> !spi_clk;
  endproperty
  a_port_off: assert property (p_port_off) else $error("port on with pin low");
  a_port_on: assert property (p_port_on) else $error("port off with pin high");
  a_adc_clear: assert property (p_adc_clear) else $error("test mode kept");
  a_adc_pair: assert property (p_adc_pair) else $error("adc controls differ");
  a_adc_rise: assert property (p_adc_rise) else $error("test mode without port");
  a_fuse_len: assert property (p_fuse_len) else $error("fuse run length wrong");
  a_fuse_bound: assert property (p_fuse_bound) else $error("fuse run too long");
  a_fuse_abort: assert property (p_fuse_abort) else $error("fuse run kept with port off");
  a_dout_idle: assert property (p_dout_idle) else $error("dout outside window");
  a_dout_fall: assert property (p_dout_fall) else $error("dout moved at clock high");
  c_adc: cover property (@(posedge core_clk) $rose(adc_ctrl.buffers_off));
  c_fuse: cover property (@(posedge core_clk) $fell(fuse_prog_active));
  c_port: cover property (@(posedge core_clk) $rose(port_enabled));
endmodule : tmsa_top_chk
bind tmsa_top tmsa_top_chk #(.FUSE_PROG_CYCLES(FUSE_PROG_CYCLES)) u_chk (.core_clk(core_clk), .reset(reset),
  .test_entry_voltage_above(test_entry_voltage_above), .spi_clk(spi_clk), .spi_din(spi_din), .spi_dout(spi_dout),
  .adc_ctrl(adc_ctrl), .fuse_prog_active(fuse_prog_active), .port_enabled(port_enabled));

// >>> testbench/test_mode_serial_access_tb.sv
`timescale 1ns/10ps
module test_mode_serial_access_tb;
  localparam int FC = 20;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic tev = 1'b0;
  logic spi_clk, spi_din, spi_dout, fuse_prog_active, port_enabled;
  tmsa_pkg::tmsa_adc_ctrl_t adc_ctrl;
  int err_total = 0;
  int comparisons = 0;
  int seed = 32'h9026;
  int n;
  logic [7:0] rd;
  logic [5:0] a;
  always #10 core_clk = ~core_clk;
  tmsa_top #(.FUSE_PROG_CYCLES(FC)) dut (.core_clk(core_clk), .reset(reset), .test_entry_voltage_above(tev),
    .spi_clk(spi_clk), .spi_din(spi_din), .spi_dout(spi_dout), .adc_ctrl(adc_ctrl),
    .fuse_prog_active(fuse_prog_active), .port_enabled(port_enabled));
  tmsa_host host (.spi_clk(spi_clk), .spi_din(spi_din), .spi_dout(spi_dout));
  // key bits 1..2 are masked off or set by the caller
  function automatic logic [7:0] st_exp(input logic adc, input logic fd);
    return {2'b00, fd, 4'h0, adc};
  endfunction : st_exp
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc
  task wr(input logic [5:0] ad, input logic [7:0] d);
    host.xfer({ad, 2'b10, d}, rd);
    cyc(8);
  endtask : wr
  task key(input logic [7:0] k3);
    wr(6'h30, 8'hAA);
    wr(6'h30, 8'h55);
    wr(6'h30, k3);
  endtask : key
  task pin(input logic v);
    cyc(1);
    tev = v;
    n = 0;
    while (port_enabled !== v && n < 20) begin
      cyc(1);
      n++;
    end
    chk("port_enabled", v, port_enabled);
    cyc(2);
  endtask : pin
  initial begin
    cyc(16);
    reset = 1'b0;
    cyc(4);
    chk("port_enabled", 0, port_enabled);
    pin(1);
    host.xfer({6'h31, 2'b00, 8'h00}, rd);
    chk("status", st_exp(0, 0), rd & 8'hF9);
    host.xfer({6'h30, 2'b00, 8'h5A}, rd);
    chk("key read", 0, rd);
    for (int i = 0; i < 6; i++) begin
      a = 6'($random(seed));
      if (a == 6'h20 || a == 6'h30 || a == 6'h31) a = 6'h01;
      wr(a, 8'($random(seed)));
      host.xfer({a, 2'b00, 8'h00}, rd);
      chk("unmapped", 0, rd);
    end
    key(8'hC6);
    chk("adc", 0, adc_ctrl);
    wr(6'h30, 8'hAA);
    host.xfer({6'h31, 2'b00, 8'h00}, rd);
    chk("status", st_exp(0, 0) | 8'h02, rd);
    wr(6'h30, 8'h12);
    wr(6'h30, 8'h55);
    wr(6'h30, 8'h1D);
    chk("adc", 0, adc_ctrl);
    key(8'h1D);
    chk("adc", 2'b11, adc_ctrl);
    host.xfer({6'h31, 2'b00, 8'h00}, rd);
    chk("status", st_exp(1, 0), rd & 8'hF9);
    pin(0);
    chk("adc", 0, adc_ctrl);
    pin(1);
    chk("adc", 0, adc_ctrl);
    host.xfer({6'h20, 2'b10, 8'h05}, rd);
    n = 0;
    while (fuse_prog_active !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (fuse_prog_active === 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk("fuse cycles", 16'(FC), 16'(n));
    host.xfer({6'h31, 2'b00, 8'h00}, rd);
    chk("status", st_exp(0, 1), rd & 8'hF9);
    // a run cut short by lowering the test pin
    host.xfer({6'h20, 2'b10, 8'h05}, rd);
    cyc(8);
    chk("fuse_prog_active", 1, fuse_prog_active);
    pin(0);
    chk("fuse_prog_active", 0, fuse_prog_active);
    pin(1);
    key(8'h1D);
    reset = 1'b1;
    cyc(4);
    chk("adc", 0, adc_ctrl);
    reset = 1'b0;
    cyc(6);
    chk("adc", 0, adc_ctrl);
    summarize();
  end
  // run needs roughly 110 us
  initial begin
    #400000;
    err_total++;
    summarize();
  end
endmodule : test_mode_serial_access_tb
